// ===== core/ssr_frame_tx.sv
// Byte serializer for one reading response frame.
// Assumes a consumer that takes a byte on each edge where valid and ready are both high.
`timescale 1ns/1ns
`default_nettype none
module ssr_frame_tx (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Frame request and contents.
    input  wire logic        start_i,
    input  wire logic [7:0]  current_level_i,
    input  wire logic [7:0]  prior_level_i,
    input  wire logic [7:0]  latched_event_level_i,
    input  wire logic [63:0] latest_value_i,
    input  wire logic [2:0]  value_width_code_i,
    // Byte stream.
    output logic             byte_valid_o,
    output logic [7:0]       byte_data_o,
    output logic             byte_last_o,
    input  wire logic        byte_ready_i,
    // Status.
    output logic             busy_o,
    output logic             done_o
);
    import ssr_pkg::*;

    typedef enum logic [1:0] {
        SSR_TX_IDLE = 2'b01,
        SSR_TX_SEND = 2'b10
    } ssr_tx_state_t;

    typedef struct packed {
        ssr_tx_state_t st;
        logic [87:0]   shift;
        logic [3:0]    left;
        logic          done;
    } ssr_tx_t;

    ssr_tx_t tx_ff;
    ssr_tx_t nxt_tx;

    always_comb begin
        nxt_tx      = tx_ff;
        nxt_tx.done = 1'b0;
        unique case (tx_ff.st)
            SSR_TX_IDLE: begin
                if (start_i) begin
                    nxt_tx.shift = {latest_value_i, latched_event_level_i,
                                    prior_level_i, current_level_i};
                    nxt_tx.left  = SSR_LEVEL_BYTES + ssr_value_bytes(value_width_code_i);
                    nxt_tx.st    = SSR_TX_SEND;
                end
            end
            SSR_TX_SEND: begin
                if (byte_ready_i) begin
                    nxt_tx.shift = {8'h00, tx_ff.shift[87:8]};
                    nxt_tx.left  = tx_ff.left - 4'h1;
                    if (tx_ff.left == 4'h1) begin
                        nxt_tx.st   = SSR_TX_IDLE;
                        nxt_tx.done = 1'b1;
                    end
                end
            end
            default: begin
                nxt_tx.st = SSR_TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_ff <= '{st: SSR_TX_IDLE, shift: '0, left: 4'h0, done: 1'b0};
        end else begin
            tx_ff <= nxt_tx;
        end
    end

    assign byte_valid_o = (tx_ff.st == SSR_TX_SEND);
    assign byte_data_o  = tx_ff.shift[7:0];
    assign byte_last_o  = (tx_ff.st == SSR_TX_SEND) && (tx_ff.left == 4'h1);
    assign busy_o       = (tx_ff.st == SSR_TX_SEND);
    assign done_o       = tx_ff.done;

endmodule : ssr_frame_tx
`default_nettype wire

// ===== core/ssr_pkg.sv
// Constants, codes and helpers shared by the sensor state reporter.
// Assumes a single clock domain and a classic Wishbone register slave.
package ssr_pkg;

    // Register byte offsets.
    localparam logic [7:0] SSR_REG_CTRL     = 8'h00;
    localparam logic [7:0] SSR_REG_LEVELS   = 8'h04;
    localparam logic [7:0] SSR_REG_VALUE_LO = 8'h08;
    localparam logic [7:0] SSR_REG_VALUE_HI = 8'h0C;
    localparam logic [7:0] SSR_REG_INT_STAT = 8'h10;
    localparam logic [7:0] SSR_REG_INT_CLR  = 8'h14;
    localparam logic [7:0] SSR_REG_INT_EN   = 8'h18;
    localparam logic [7:0] SSR_REG_REQ      = 8'h1C;

    // Control register field positions.
    localparam int SSR_CTRL_OP_LSB    = 0;
    localparam int SSR_CTRL_WIDTH_LSB = 8;
    localparam int SSR_CTRL_ONREQ_BIT = 11;

    // Interrupt status bit positions.
    localparam int SSR_IRQ_LEVEL_CHG = 0;
    localparam int SSR_IRQ_EVENT_CHG = 1;
    localparam int SSR_IRQ_FRAME_END = 2;
    localparam int SSR_IRQ_W         = 3;

    // Number of fixed level bytes ahead of the value in a frame.
    localparam logic [3:0] SSR_LEVEL_BYTES = 4'h3;

    // Eleven level codes carried as an 8-bit enumeration.
    localparam logic [7:0] SSR_LVL_UNKNOWN  = 8'h00;
    localparam logic [7:0] SSR_LVL_NORMAL   = 8'h01;
    localparam logic [7:0] SSR_LVL_LAST     = 8'h0A;

    // Operational conditions, 8-bit codes.
    localparam logic [7:0] SSR_OP_ENABLED   = 8'h00;
    localparam logic [7:0] SSR_OP_DISABLED  = 8'h01;
    localparam logic [7:0] SSR_OP_UNAVAIL   = 8'h02;

    // Reset values.
    localparam logic [7:0] SSR_RST_OP       = SSR_OP_DISABLED;
    localparam logic [2:0] SSR_RST_WIDTH    = 3'h0;

    // Value width codes: uint8, sint8, uint16, sint16, uint32, sint32, uint64, sint64.
    typedef enum logic [2:0] {
        SSR_W_U8  = 3'h0,
        SSR_W_S8  = 3'h1,
        SSR_W_U16 = 3'h2,
        SSR_W_S16 = 3'h3,
        SSR_W_U32 = 3'h4,
        SSR_W_S32 = 3'h5,
        SSR_W_U64 = 3'h6,
        SSR_W_S64 = 3'h7
    } ssr_width_t;

    // Bytes that a value of the given width code occupies.
    function automatic logic [3:0] ssr_value_bytes(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h1 << code[2:1];
        return n;
    endfunction : ssr_value_bytes

endpackage : ssr_pkg

// ===== core/ssr_reporter.sv
// Sensor state reporter: tracks current, prior and latched event levels and the latest value,
// exposes them over classic Wishbone and serializes them as a reading response frame.
// Assumes level assessments and samples arrive as synchronous strobes from the sensing logic.
`timescale 1ns/1ns
`default_nettype none
module ssr_reporter (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave.
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Sensing side.
    input  wire logic        assess_valid_i,
    input  wire logic [7:0]  assess_level_i,
    input  wire logic        event_valid_i,
    input  wire logic [7:0]  event_level_i,
    input  wire logic        sample_valid_i,
    input  wire logic [63:0] sample_i,
    // Reading request and response stream.
    input  wire logic        read_req_i,
    output logic             resp_valid_o,
    output logic [7:0]       resp_data_o,
    output logic             resp_last_o,
    input  wire logic        resp_ready_i,
    output logic             resp_busy_o,
    // Interrupt.
    output logic             irq_o
);
    import ssr_pkg::*;

    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic [7:0]           op_condition;
        logic [2:0]           value_width_code;
        logic                 on_request;
        logic [7:0]           current_level;
        logic [7:0]           prior_level;
        logic [7:0]           latched_event_level;
        logic [63:0]          latest_value;
        logic [SSR_IRQ_W-1:0] irq_stat;
        logic [SSR_IRQ_W-1:0] irq_en;
        logic                 start;
    } ssr_state_t;

    ssr_state_t s_ff;
    ssr_state_t nxt_s;

    logic tx_busy;
    logic tx_done;

    // A level code is usable only if it is one of the assessed, non-Unknown states.
    function automatic logic ssr_level_ok(input logic [7:0] code);
        logic ok;
        ok = (code != SSR_LVL_UNKNOWN) && (code <= SSR_LVL_LAST);
        return ok;
    endfunction : ssr_level_ok

    // Trim a sample to the selected width, extending the sign for signed codes.
    function automatic logic [63:0] ssr_fit(input logic [63:0] v, input logic [2:0] code);
        logic [63:0] r;
        r = v;
        unique case (code[2:1])
            2'h0: r = {{56{code[0] & v[7]}},  v[7:0]};
            2'h1: r = {{48{code[0] & v[15]}}, v[15:0]};
            2'h2: r = {{32{code[0] & v[31]}}, v[31:0]};
            2'h3: r = v;
        endcase
        return r;
    endfunction : ssr_fit

    logic                 bus_wr;
    logic                 bus_rd;
    logic                 enabled;
    logic                 req;
    logic [7:0]           base_cur;
    logic [SSR_IRQ_W-1:0] irq_set;
    logic [SSR_IRQ_W-1:0] irq_clr;

    always_comb begin
        nxt_s    = s_ff;
        bus_wr   = cyc_i && stb_i && we_i && !s_ff.ack;
        bus_rd   = cyc_i && stb_i && !we_i && !s_ff.ack;
        irq_set  = '0;
        irq_clr  = '0;
        req      = read_req_i;
        base_cur = s_ff.current_level;

        // The answer comes one edge after the request and is dropped the edge after.
        nxt_s.ack   = cyc_i && stb_i && !s_ff.ack;
        nxt_s.start = 1'b0;

        if (bus_wr) begin
            unique case (adr_i)
                SSR_REG_CTRL: begin
                    if (sel_i[0]) begin
                        nxt_s.op_condition = dat_i[SSR_CTRL_OP_LSB +: 8];
                    end
                    if (sel_i[1]) begin
                        nxt_s.value_width_code = dat_i[SSR_CTRL_WIDTH_LSB +: 3];
                        nxt_s.on_request       = dat_i[SSR_CTRL_ONREQ_BIT];
                    end
                end
                SSR_REG_INT_CLR: begin
                    if (sel_i[0]) begin
                        irq_clr = dat_i[SSR_IRQ_W-1:0];
                    end
                end
                SSR_REG_INT_EN: begin
                    if (sel_i[0]) begin
                        nxt_s.irq_en = dat_i[SSR_IRQ_W-1:0];
                    end
                end
                SSR_REG_REQ: begin
                    if (sel_i[0] && dat_i[0]) begin
                        req = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        if (bus_rd) begin
            unique case (adr_i)
                SSR_REG_CTRL: begin
                    nxt_s.rdat = {20'h00000, s_ff.on_request, s_ff.value_width_code,
                                  s_ff.op_condition};
                end
                SSR_REG_LEVELS: begin
                    nxt_s.rdat = {8'h00, s_ff.latched_event_level, s_ff.prior_level,
                                  s_ff.current_level};
                end
                SSR_REG_VALUE_LO: begin
                    nxt_s.rdat = s_ff.latest_value[31:0];
                end
                SSR_REG_VALUE_HI: begin
                    nxt_s.rdat = s_ff.latest_value[63:32];
                end
                SSR_REG_INT_STAT: begin
                    nxt_s.rdat = {29'h00000000, s_ff.irq_stat};
                end
                SSR_REG_INT_EN: begin
                    nxt_s.rdat = {29'h00000000, s_ff.irq_en};
                end
                SSR_REG_REQ: begin
                    nxt_s.rdat = {31'h00000000, tx_busy};
                end
                default: begin
                    // Unmapped and write-only offsets answer with zero.
                    nxt_s.rdat = 32'h00000000;
                end
            endcase
        end

        enabled = (s_ff.op_condition == SSR_OP_ENABLED);

        if (!enabled) begin
            nxt_s.current_level       = SSR_LVL_UNKNOWN;
            nxt_s.prior_level         = SSR_LVL_UNKNOWN;
            nxt_s.latched_event_level = SSR_LVL_UNKNOWN;
        end else begin
            if (!ssr_level_ok(s_ff.current_level)) begin
                base_cur = SSR_LVL_NORMAL;
            end
            nxt_s.current_level = base_cur;
            if (assess_valid_i && ssr_level_ok(assess_level_i) && assess_level_i != base_cur) begin
                nxt_s.current_level = assess_level_i;
                nxt_s.prior_level   = base_cur;
                irq_set[SSR_IRQ_LEVEL_CHG] = 1'b1;
            end
            if (event_valid_i && ssr_level_ok(event_level_i)
                    && event_level_i != s_ff.latched_event_level) begin
                nxt_s.latched_event_level = event_level_i;
                irq_set[SSR_IRQ_EVENT_CHG] = 1'b1;
            end
        end

        // periodic sampling or capture at request
        if (!s_ff.on_request && sample_valid_i) begin
            nxt_s.latest_value = ssr_fit(sample_i, s_ff.value_width_code);
        end
        // A request while a frame is still going out is dropped.
        if (req && !tx_busy && !s_ff.start) begin
            if (s_ff.on_request) begin
                nxt_s.latest_value = ssr_fit(sample_i, s_ff.value_width_code);
            end
            // Starting a cycle later lets the frame see the value just captured.
            nxt_s.start = 1'b1;
        end

        irq_set[SSR_IRQ_FRAME_END] = tx_done;
        // A new event wins over a clear in the same cycle.
        nxt_s.irq_stat = (s_ff.irq_stat & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff <= '{ack: 1'b0, rdat: 32'h00000000, op_condition: SSR_RST_OP,
                      value_width_code: SSR_RST_WIDTH, on_request: 1'b0,
                      current_level: SSR_LVL_UNKNOWN, prior_level: SSR_LVL_UNKNOWN,
                      latched_event_level: SSR_LVL_UNKNOWN, latest_value: 64'h0,
                      irq_stat: '0, irq_en: '0, start: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    ssr_frame_tx u_frame_tx (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .start_i               (s_ff.start),
        .current_level_i       (s_ff.current_level),
        .prior_level_i         (s_ff.prior_level),
        .latched_event_level_i (s_ff.latched_event_level),
        .latest_value_i        (s_ff.latest_value),
        .value_width_code_i    (s_ff.value_width_code),
        .byte_valid_o          (resp_valid_o),
        .byte_data_o           (resp_data_o),
        .byte_last_o           (resp_last_o),
        .byte_ready_i          (resp_ready_i),
        .busy_o                (tx_busy),
        .done_o                (tx_done)
    );

    assign dat_o       = s_ff.rdat;
    assign ack_o       = s_ff.ack;
    assign resp_busy_o = tx_busy || s_ff.start;
    assign irq_o       = |(s_ff.irq_stat & s_ff.irq_en);

endmodule : ssr_reporter
`default_nettype wire

// ===== sim/ssr_host_model.sv
// Reading requester that takes response bytes at full or reduced rate.
// Assumes the bench pulses go_i for one cycle and reads got_ff by name.
`timescale 1ns/1ns
`default_nettype none
module ssr_host_model (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Bench control.
    input  wire logic       go_i,
    input  wire logic       slow_i,
    input  wire logic       en_i,
    // Response stream.
    input  wire logic       busy_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    output logic            req_o,
    output logic            ready_o
);
    logic [7:0] got_ff [16];
    logic [3:0] cnt_ff;
    logic [1:0] ph_ff;
    logic       ok_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_o   <= 1'b0;
            ready_o <= 1'b0;
            cnt_ff  <= 4'h0;
            ph_ff   <= 2'h0;
            ok_ff   <= 1'b0;
        end else begin
            ph_ff   <= ph_ff + 2'h1;
            req_o   <= go_i;
            // Slow mode takes one byte in four, so the serializer must hold its offer.
            ready_o <= !slow_i || ph_ff == 2'h0;
            if (go_i && !busy_i) begin
                cnt_ff <= 4'h0;
                ok_ff  <= en_i;
            end else if (valid_i && ready_o) begin
                got_ff[cnt_ff] <= data_i;
                cnt_ff         <= cnt_ff + 4'h1;
            end
        end
    end
endmodule : ssr_host_model
`default_nettype wire

// ===== sim/ssr_reporter_asserts.sv
// Port checker for the sensor state reporter frame stream and bus.
// Assumes the control register is written only while no frame is pending.
`timescale 1ns/1ns
`default_nettype none
module ssr_reporter_asserts
    import ssr_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic        ack_o,
    // Frame stream.
    input wire logic        read_req_i,
    input wire logic        resp_valid_o,
    input wire logic [7:0]  resp_data_o,
    input wire logic        resp_last_o,
    input wire logic        resp_ready_i,
    input wire logic        resp_busy_o
);
    logic [7:0] op_ff;
    logic [2:0] wid_ff;
    logic [3:0] idx_ff;
    logic [7:0] cur_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_ff  <= SSR_RST_OP;
            wid_ff <= SSR_RST_WIDTH;
        end else if (cyc_i && stb_i && we_i && !ack_o && adr_i == SSR_REG_CTRL) begin
            op_ff  <= dat_i[7:0];
            wid_ff <= dat_i[10:8];
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_ff <= 4'h0;
        end else if (resp_valid_o && resp_ready_i) begin
            idx_ff <= resp_last_o ? 4'h0 : idx_ff + 4'h1;
            cur_ff <= (idx_ff == 4'h0) ? resp_data_o : cur_ff;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_taken;
        read_req_i && !resp_busy_o;
    endsequence
    sequence s_first_byte;
        !resp_valid_o ##1 resp_valid_o;
    endsequence
    chk_lvl_unknown_off: assert property (
        resp_valid_o && idx_ff < 4'h3 && op_ff != SSR_OP_ENABLED |-> resp_data_o == 8'h00)
        else $error("level byte not Unknown while not enabled");
    chk_cur_known_on: assert property (
        resp_valid_o && idx_ff == 4'h0 && op_ff == SSR_OP_ENABLED
        |-> resp_data_o inside {[SSR_LVL_NORMAL:SSR_LVL_LAST]})
        else $error("current level not a known code while enabled");
    chk_prior_differs: assert property (
        resp_valid_o && idx_ff == 4'h1 && resp_data_o == cur_ff |-> cur_ff == 8'h00)
        else $error("prior level equals a known current level");
    chk_event_legal: assert property (
        resp_valid_o && idx_ff == 4'h2 |-> resp_data_o <= SSR_LVL_LAST)
        else $error("latched event level outside the code set");
    chk_frame_last: assert property (
        resp_valid_o |-> resp_last_o == (idx_ff == 4'h2 + (4'h1 << wid_ff[2:1])))
        else $error("last byte flag at wrong position");
    chk_byte_hold: assert property (
        resp_valid_o && !resp_ready_i |=> resp_valid_o && $stable(resp_data_o))
        else $error("offered byte changed before acceptance");
    chk_frame_start: assert property (
        s_taken |=> s_first_byte)
        else $error("first byte not offered two cycles after request");
    chk_bus_ack: assert property (
        cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus acknowledge not a one cycle pulse");
endmodule : ssr_reporter_asserts
`default_nettype wire

// ===== sim/tb_sensor_state_reporter.sv
// Self-checking bench for the sensor state reporter.
// Assumes the host model and the port checker are compiled ahead of it.
`timescale 1ns/1ns
`default_nettype none
module tb_sensor_state_reporter;
    import ssr_pkg::*;
    localparam logic [63:0] SMP_A = 64'hC877665584339281;
    localparam logic [63:0] SMP_B = 64'h0F1E2D3C4B5A6978;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        asv = 1'b0, evv = 1'b0, smv = 1'b0, go = 1'b0, slow = 1'b0, en = 1'b0;
    logic [7:0]  adr_i = 8'h00, lvl = 8'h00, rdata, cur = 8'h01, pri = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, rdat;
    logic [63:0] smp = 64'h0;
    logic        ack_o, req, rdy, vld, lst, busy, irq;
    int          fail_count = 0, checked = 0, cyc_n = 0;
    ssr_reporter u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .assess_valid_i(asv), .assess_level_i(lvl), .event_valid_i(evv),
        .event_level_i(lvl), .sample_valid_i(smv), .sample_i(smp), .read_req_i(req),
        .resp_valid_o(vld), .resp_data_o(rdata), .resp_last_o(lst), .resp_ready_i(rdy),
        .resp_busy_o(busy), .irq_o(irq));
    ssr_host_model u_host (
        .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .slow_i(slow), .en_i(en), .busy_i(busy),
        .valid_i(vld), .data_i(rdata), .req_o(req), .ready_o(rdy));
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        check("bus ack", n < 20, 1'b1);
        rdat = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        check(what, rdat, exp);
    endtask : rdchk
    task automatic ctrl(input logic [31:0] v);
        en <= (v[7:0] == SSR_OP_ENABLED);
        wb(1'b1, SSR_REG_CTRL, v);
    endtask : ctrl
    task automatic pulse_lvl(input logic ev, input logic [7:0] code);
        asv <= !ev;
        evv <= ev;
        lvl <= code;
        @(posedge clk_i);
        asv <= 1'b0;
        evv <= 1'b0;
        @(posedge clk_i);
    endtask : pulse_lvl
    task automatic frame();
        int n;
        n = 0;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
        // A second request while the first is going out must be dropped.
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        while (busy !== 1'b0 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        check("frame done", n < 400, 1'b1);
        @(posedge clk_i);
    endtask : frame
    task automatic t_reset();
        rdchk("ctrl reset", SSR_REG_CTRL, 32'h1);
        rdchk("levels reset", SSR_REG_LEVELS, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        check("irq reset", irq, 1'b0);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_levels();
        ctrl(32'h0);
        rdchk("levels on", SSR_REG_LEVELS, 32'h1);
        pulse_lvl(1'b1, 8'h05);
        rdchk("event", SSR_REG_LEVELS, 32'h00050001);
        for (int k = 0; k < 12; k++) begin
            pulse_lvl(1'b0, 8'(k));
            if (k >= 1 && k <= 10 && k != cur) begin
                pri = cur;
                cur = 8'(k);
            end
            rdchk("levels", SSR_REG_LEVELS, {8'h00, 8'h05, pri, cur});
        end
        $display("t_levels done");
    endtask : t_levels
    task automatic t_irq();
        rdchk("status", SSR_REG_INT_STAT, 32'h3);
        check("irq masked", irq, 1'b0);
        wb(1'b1, SSR_REG_INT_EN, 32'h1);
        check("irq raised", irq, 1'b1);
        wb(1'b1, SSR_REG_INT_CLR, 32'h1);
        check("irq cleared", irq, 1'b0);
        wb(1'b1, SSR_REG_INT_CLR, 32'h2);
        rdchk("status clear", SSR_REG_INT_STAT, 32'h0);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_frame();
        logic [63:0] v;
        int nb;
        for (int w = 0; w < 8; w++) begin
            nb = 1 << (w >> 1);
            v = SMP_A;
            for (int i = nb; i < 8; i++) begin
                v[8*i +: 8] = (w[0] && SMP_A[8*nb-1]) ? 8'hFF : 8'h00;
            end
            slow <= w[0];
            ctrl(w << 8);
            // The value is trimmed when it is captured, so each width needs a fresh sample.
            smp <= SMP_A;
            smv <= 1'b1;
            @(posedge clk_i);
            smv <= 1'b0;
            // A sample change without its strobe must not reach a periodic frame.
            smp <= SMP_B;
            frame();
            check("byte count", u_host.cnt_ff, 3 + nb);
            check("current", u_host.got_ff[0], cur);
            check("prior", u_host.got_ff[1], pri);
            check("event", u_host.got_ff[2], 8'h05);
            for (int i = 0; i < nb; i++) begin
                check("value byte", u_host.got_ff[3+i], SMP_A[8*i +: 8]);
            end
            rdchk("value lo", SSR_REG_VALUE_LO, v[31:0]);
            rdchk("value hi", SSR_REG_VALUE_HI, v[63:32]);
        end
        rdchk("frame status", SSR_REG_INT_STAT, 32'h4);
        ctrl(32'h00000E00);
        frame();
        check("request byte", u_host.got_ff[3], SMP_B[7:0]);
        check("request top", u_host.got_ff[10], SMP_B[63:56]);
        // A request through the register must start a frame that shows as busy.
        wb(1'b1, SSR_REG_REQ, 32'h1);
        rdchk("req busy", SSR_REG_REQ, 32'h1);
        repeat (60) @(posedge clk_i);
        rdchk("req idle", SSR_REG_REQ, 32'h0);
        $display("t_frame done");
    endtask : t_frame
    task automatic t_disable();
        for (int op = 1; op < 8; op++) begin
            ctrl(op);
            rdchk("levels off", SSR_REG_LEVELS, 32'h0);
        end
        frame();
        check("off frame", {u_host.got_ff[0], u_host.got_ff[1], u_host.got_ff[2]}, 24'h0);
        check("ignored", u_host.ok_ff, 1'b0);
        ctrl(32'h0);
        rdchk("re-enabled", SSR_REG_LEVELS, 32'h1);
        $display("t_disable done");
    endtask : t_disable
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_levels();
        t_irq();
        t_frame();
        t_disable();
        final_report();
    end
endmodule : tb_sensor_state_reporter
bind ssr_reporter ssr_reporter_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .read_req_i(read_req_i),
    .resp_valid_o(resp_valid_o), .resp_data_o(resp_data_o), .resp_last_o(resp_last_o),
    .resp_ready_i(resp_ready_i), .resp_busy_o(resp_busy_o));
`default_nettype wire
